// ---- common/umsft_pkg.sv ----
package umsft_pkg;
	localparam int ADDR_W = 4;
	localparam int CNT_W = 7;
	localparam int NIB_W = 4;
	localparam logic [ADDR_W-1:0] OFS_STATUS_OR_LEVELS = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_SCRATCH_OR_TRIG = 4'h7;
	localparam logic [7:0] LCR_XOFF_KEY = 8'hBF;
	localparam logic [7:0] UNLOCK_KEY = 8'h5A;
	localparam int LCR_DLAB = 7;
	localparam int EFR_ENH = 4;
	localparam int SFR_BANK = 2;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_OP1 = 2;
	localparam int MCR_OP2 = 3;
	localparam int MCR_LOOP = 4;
	// Line index inside the modem vector; status bit is index plus STATUS_LSB
	localparam int LN_CTS = 0;
	localparam int LN_DSR = 1;
	localparam int LN_RI = 2;
	localparam int LN_CD = 3;
	localparam int STATUS_LSB = 4;
	localparam int LVL_HI_LSB = 4;
	localparam int LVL_LO_LSB = 0;
	localparam int FCR_RX_SEL_LSB = 6;
	localparam int FCR_TX_SEL_LSB = 4;
	localparam int TRIG_ENTRY_W = 7;
	localparam logic [7:0] LEVELS_RST = 8'h00;
	localparam logic [7:0] TRIG_RST = 8'h00;
	localparam logic [7:0] XOFF_RST = 8'h00;
	localparam logic [7:0] SCRATCH_RST = 8'hFF;
	localparam logic [3:0] DELTA_RST = 4'h0;
	localparam logic [3:0] LINES_IDLE_N = 4'hF;
endpackage

// ---- src/umsft_pin_sync.sv ----
`timescale 1ns/1ps
module umsft_pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] stage1;

	// Two flops per pin; the first is seen only by the second
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					stage1[gi] <= RESET_VAL[gi];
					pin_sync[gi] <= RESET_VAL[gi];
				end else begin
					stage1[gi] <= pin_in[gi];
					pin_sync[gi] <= stage1[gi];
				end
			end
		end
	endgenerate
endmodule

// ---- src/umsft_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Ring status is inverted pin, loopback mirrors OP1
// - DSR status is inverted pin, loopback mirrors DTR
// - CTS status is inverted pin, loopback mirrors RTS
// - Carrier change flag sets on any edge
// - Ring change flag sets on rising pin only
// - DSR change flag sets on any edge
// - CTS change flag sets on any edge
// - Any change flag plus enable raises interrupt
// - Level register needs enhanced, OP1, bank zero
// - Fill at or below resume level: resume
// - Fill at or above halt level: halt
// - First Xoff byte reached under key 0xBF
// - Xoff and scratch cleared by power-on only
// - Scratch byte is plain storage, powers up ones
// - Scratch reached with DLAB and OP1 clear
// - Receive ready when count reaches receive trigger
// - Transmit ready when space reaches transmit trigger
// - Second Xoff byte reached under key, no unlock
// - OP1 selects which pair each offset shows
// - Carrier status is inverted pin, loopback mirrors OP2
module umsft_top #(
	parameter logic [27:0] RX_TRIG_TABLE = {7'h3C, 7'h38, 7'h10, 7'h08},
	parameter logic [27:0] TX_TRIG_TABLE = {7'h38, 7'h20, 7'h10, 7'h08}
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sw_reset,
	input wire logic [umsft_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] line_control,
	input wire logic [7:0] modem_control,
	input wire logic [7:0] enhanced_function_control,
	input wire logic [7:0] special_function_control,
	input wire logic [7:0] special_function_unlock_code,
	input wire logic [7:0] fifo_control,
	input wire logic msr_int_enable,
	input wire logic auto_rts_en,
	input wire logic auto_swflow_en,
	input wire logic [umsft_pkg::CNT_W-1:0] rx_fifo_count,
	input wire logic [umsft_pkg::CNT_W-1:0] tx_fifo_space,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ring_indicator_n,
	input wire logic carrier_detect_n,
	output logic modem_irq,
	output logic rx_ready_irq,
	output logic tx_ready_irq,
	output logic flow_halt,
	output logic xon_req,
	output logic xoff_req,
	output logic [7:0] xoff_char_first,
	output logic [7:0] xoff_char_second
);
	localparam int CW = umsft_pkg::CNT_W;
	localparam int NW = umsft_pkg::NIB_W;
	localparam int EW = umsft_pkg::TRIG_ENTRY_W;

	logic [7:0] flow_halt_resume_levels;
	logic [7:0] fifo_trigger_levels;
	logic [7:0] scratch_byte;
	logic [3:0] pin_n_s;
	logic [3:0] loop_n;
	logic [3:0] line_n;
	logic [3:0] line_prev;
	logic [3:0] line_evt;
	logic [3:0] delta;
	logic [3:0] next_delta;
	logic [7:0] modem_line_status;
	logic loop_en;
	logic sel_levels;
	logic lcr_key;
	logic bank_zero;
	logic hit_msr, hit_tcr, hit_xoff_char_first, hit_spr, hit_tlr, hit_xoff_char_second;
	logic [CW-1:0] halt_lvl, resume_lvl, rx_lvl, tx_lvl;
	logic [7:0] next_rdata;

	function automatic logic [CW-1:0] times4(input logic [NW-1:0] nib);
		times4 = CW'({nib, 2'b00});
	endfunction

	umsft_pin_sync #(.WIDTH(4), .RESET_VAL(umsft_pkg::LINES_IDLE_N)) u_pin_sync (
		.clk(clk),
		.nrst(nrst),
		.pin_in({carrier_detect_n, ring_indicator_n, dsr_n, cts_n}),
		.pin_sync(pin_n_s)
	);

	// Modem lines, active low, with loopback taking them from modem control
	assign loop_en = modem_control[umsft_pkg::MCR_LOOP];
	assign loop_n = ~{modem_control[umsft_pkg::MCR_OP2], modem_control[umsft_pkg::MCR_OP1],
		modem_control[umsft_pkg::MCR_DTR], modem_control[umsft_pkg::MCR_RTS]};
	assign line_n = loop_en ? loop_n : pin_n_s;
	assign modem_line_status = {~line_n, delta};

	assign line_evt[umsft_pkg::LN_CTS] = line_n[umsft_pkg::LN_CTS] ^ line_prev[umsft_pkg::LN_CTS];
	assign line_evt[umsft_pkg::LN_DSR] = line_n[umsft_pkg::LN_DSR] ^ line_prev[umsft_pkg::LN_DSR];
	assign line_evt[umsft_pkg::LN_RI] = line_n[umsft_pkg::LN_RI] & ~line_prev[umsft_pkg::LN_RI];
	assign line_evt[umsft_pkg::LN_CD] = line_n[umsft_pkg::LN_CD] ^ line_prev[umsft_pkg::LN_CD];

	// Register selection
	assign sel_levels = modem_control[umsft_pkg::MCR_OP1];
	assign lcr_key = line_control == umsft_pkg::LCR_XOFF_KEY;
	assign bank_zero = !special_function_control[umsft_pkg::SFR_BANK];
	assign hit_xoff_char_first = reg_addr == umsft_pkg::OFS_STATUS_OR_LEVELS && lcr_key && bank_zero;
	assign hit_msr = reg_addr == umsft_pkg::OFS_STATUS_OR_LEVELS && !lcr_key &&
		!line_control[umsft_pkg::LCR_DLAB] && !sel_levels && bank_zero;
	assign hit_tcr = reg_addr == umsft_pkg::OFS_STATUS_OR_LEVELS && !lcr_key &&
		enhanced_function_control[umsft_pkg::EFR_ENH] && sel_levels && bank_zero;
	assign hit_xoff_char_second = reg_addr == umsft_pkg::OFS_SCRATCH_OR_TRIG && lcr_key &&
		special_function_unlock_code != umsft_pkg::UNLOCK_KEY;
	assign hit_spr = reg_addr == umsft_pkg::OFS_SCRATCH_OR_TRIG && !hit_xoff_char_second &&
		!line_control[umsft_pkg::LCR_DLAB] && !sel_levels;
	assign hit_tlr = reg_addr == umsft_pkg::OFS_SCRATCH_OR_TRIG && !hit_xoff_char_second &&
		enhanced_function_control[umsft_pkg::EFR_ENH] && sel_levels;

	// Change flags: a new event wins over the clear by a status read
	assign next_delta = ((reg_rd && hit_msr) ? umsft_pkg::DELTA_RST : delta) | line_evt;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			line_prev <= umsft_pkg::LINES_IDLE_N;
			delta <= umsft_pkg::DELTA_RST;
		end else begin
			line_prev <= line_n;
			delta <= sw_reset ? umsft_pkg::DELTA_RST : next_delta;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			modem_irq <= 1'b0;
		end else begin
			modem_irq <= msr_int_enable && (|delta);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flow_halt_resume_levels <= umsft_pkg::LEVELS_RST;
			fifo_trigger_levels <= umsft_pkg::TRIG_RST;
		end else if (sw_reset) begin
			flow_halt_resume_levels <= umsft_pkg::LEVELS_RST;
			fifo_trigger_levels <= umsft_pkg::TRIG_RST;
		end else begin
			if (reg_wr && hit_tcr) begin
				flow_halt_resume_levels <= reg_wdata;
			end
			if (reg_wr && hit_tlr) begin
				fifo_trigger_levels <= reg_wdata;
			end
		end
	end

	// Power-on-only storage; the software reset leaves it alone
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xoff_char_first <= umsft_pkg::XOFF_RST;
			xoff_char_second <= umsft_pkg::XOFF_RST;
			scratch_byte <= umsft_pkg::SCRATCH_RST;
		end else begin
			if (reg_wr && hit_xoff_char_first) begin
				xoff_char_first <= reg_wdata;
			end
			if (reg_wr && hit_xoff_char_second) begin
				xoff_char_second <= reg_wdata;
			end
			if (reg_wr && hit_spr) begin
				scratch_byte <= reg_wdata;
			end
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (hit_xoff_char_first) begin
			next_rdata = xoff_char_first;
		end else if (hit_msr) begin
			next_rdata = modem_line_status;
		end else if (hit_tcr) begin
			next_rdata = flow_halt_resume_levels;
		end else if (hit_xoff_char_second) begin
			next_rdata = xoff_char_second;
		end else if (hit_spr) begin
			next_rdata = scratch_byte;
		end else if (hit_tlr) begin
			next_rdata = fifo_trigger_levels;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// Flow thresholds in characters
	assign halt_lvl = times4(flow_halt_resume_levels[umsft_pkg::LVL_LO_LSB +: NW]);
	assign resume_lvl = times4(flow_halt_resume_levels[umsft_pkg::LVL_HI_LSB +: NW]);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flow_halt <= 1'b0;
			xon_req <= 1'b0;
			xoff_req <= 1'b0;
		end else begin
			xon_req <= 1'b0;
			xoff_req <= 1'b0;
			if (sw_reset) begin
				flow_halt <= 1'b0;
			end else if (!flow_halt && (auto_rts_en || auto_swflow_en) &&
				rx_fifo_count >= halt_lvl) begin
				flow_halt <= 1'b1;
				xoff_req <= auto_swflow_en;
			end else if (flow_halt && rx_fifo_count <= resume_lvl) begin
				flow_halt <= 1'b0;
				xon_req <= auto_swflow_en;
			end
		end
	end

	// Trigger levels, falling back to the fifo control choice on a zero nibble
	always_comb begin
		rx_lvl = times4(fifo_trigger_levels[umsft_pkg::LVL_HI_LSB +: NW]);
		if (fifo_trigger_levels[umsft_pkg::LVL_HI_LSB +: NW] == 4'h0) begin
			rx_lvl = CW'(RX_TRIG_TABLE[fifo_control[umsft_pkg::FCR_RX_SEL_LSB +: 2] * EW +: EW]);
		end
		tx_lvl = times4(fifo_trigger_levels[umsft_pkg::LVL_LO_LSB +: NW]);
		if (fifo_trigger_levels[umsft_pkg::LVL_LO_LSB +: NW] == 4'h0) begin
			tx_lvl = CW'(TX_TRIG_TABLE[fifo_control[umsft_pkg::FCR_TX_SEL_LSB +: 2] * EW +: EW]);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_ready_irq <= 1'b0;
			tx_ready_irq <= 1'b0;
		end else begin
			rx_ready_irq <= rx_fifo_count >= rx_lvl;
			tx_ready_irq <= tx_fifo_space >= tx_lvl;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_ri_status;
		modem_line_status[umsft_pkg::LN_RI + umsft_pkg::STATUS_LSB] ==
			(loop_en ? modem_control[umsft_pkg::MCR_OP1] : !pin_n_s[umsft_pkg::LN_RI]);
	endproperty
	a_ri_status: assert property (p_ri_status) else $error("ring status wrong");

	property p_dsr_status;
		modem_line_status[umsft_pkg::LN_DSR + umsft_pkg::STATUS_LSB] ==
			(loop_en ? modem_control[umsft_pkg::MCR_DTR] : !pin_n_s[umsft_pkg::LN_DSR]);
	endproperty
	a_dsr_status: assert property (p_dsr_status) else $error("dsr status wrong");

	property p_cts_status;
		modem_line_status[umsft_pkg::LN_CTS + umsft_pkg::STATUS_LSB] ==
			(loop_en ? modem_control[umsft_pkg::MCR_RTS] : !pin_n_s[umsft_pkg::LN_CTS]);
	endproperty
	a_cts_status: assert property (p_cts_status) else $error("cts status wrong");

	property p_cd_status;
		modem_line_status[umsft_pkg::LN_CD + umsft_pkg::STATUS_LSB] ==
			(loop_en ? modem_control[umsft_pkg::MCR_OP2] : !pin_n_s[umsft_pkg::LN_CD]);
	endproperty
	a_cd_status: assert property (p_cd_status) else $error("carrier status wrong");

	property p_cd_delta;
		$changed(line_n[umsft_pkg::LN_CD]) && !sw_reset |=> delta[umsft_pkg::LN_CD];
	endproperty
	a_cd_delta: assert property (p_cd_delta) else $error("carrier change lost");

	property p_ri_delta;
		!delta[umsft_pkg::LN_RI] && !sw_reset && $rose(line_n[umsft_pkg::LN_RI]) |=>
			delta[umsft_pkg::LN_RI];
	endproperty
	a_ri_delta: assert property (p_ri_delta) else $error("ring change wrong");
	property p_ri_quiet;
		!delta[umsft_pkg::LN_RI] && !$rose(line_n[umsft_pkg::LN_RI]) |=> !delta[umsft_pkg::LN_RI];
	endproperty
	a_ri_quiet: assert property (p_ri_quiet) else $error("ring flag set falsely");

	property p_dsr_delta;
		$changed(line_n[umsft_pkg::LN_DSR]) && !sw_reset |=> delta[umsft_pkg::LN_DSR];
	endproperty
	a_dsr_delta: assert property (p_dsr_delta) else $error("dsr change lost");

	property p_cts_delta;
		$changed(line_n[umsft_pkg::LN_CTS]) && !sw_reset |=> delta[umsft_pkg::LN_CTS];
	endproperty
	a_cts_delta: assert property (p_cts_delta) else $error("cts change lost");

	property p_modem_irq;
		(|delta) && msr_int_enable |=> modem_irq;
	endproperty
	a_modem_irq: assert property (p_modem_irq) else $error("modem irq missing");

	property p_read_clears;
		reg_rd && hit_msr && line_evt == 4'h0 |=> delta == 4'h0;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("flags not cleared");

	property p_resume;
		flow_halt && !sw_reset && rx_fifo_count <= resume_lvl |=> !flow_halt ##0 xon_req == $past(auto_swflow_en);
	endproperty
	a_resume: assert property (p_resume) else $error("flow did not resume");

	property p_halt;
		!flow_halt && !sw_reset && auto_rts_en && rx_fifo_count >= halt_lvl |=> flow_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("flow did not halt");

	property p_rx_trig;
		rx_fifo_count >= rx_lvl |=> rx_ready_irq;
	endproperty
	a_rx_trig: assert property (p_rx_trig) else $error("rx ready missing");

	property p_scratch_keep;
		sw_reset && !reg_wr |=> scratch_byte == $past(scratch_byte);
	endproperty
	a_scratch_keep: assert property (p_scratch_keep) else $error("scratch lost on soft reset");

	c_loop_irq: cover property (loop_en ##1 $changed(line_n) ##1 (|delta) ##1 modem_irq);
	c_halt_resume: cover property ($rose(flow_halt) ##[1:200] $fell(flow_halt));
	c_msr_read: cover property (reg_rd && hit_msr && (|delta));
endmodule

// ---- tb/umsft_modem_peer.sv ----
`timescale 1ns/1ps
module umsft_modem_peer (
	input wire logic [3:0] assert_lines,
	output logic cts_n,
	output logic dsr_n,
	output logic ring_indicator_n,
	output logic carrier_detect_n
);
	// Transceiver pins are active low and switch away from the clock edges
	assign #3 {carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = ~assert_lines;
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic clk, nrst, sw_reset, reg_wr, reg_rd, msr_int_enable, auto_rts_en, auto_swflow_en;
	logic [3:0] reg_addr, lines;
	logic [7:0] reg_wdata, line_control, modem_control, enhanced_function_control;
	logic [7:0] special_function_control, special_function_unlock_code, fifo_control, e;
	logic [6:0] rx_fifo_count, tx_fifo_space;
	logic [7:0] reg_rdata, xoff_char_first, xoff_char_second;
	logic modem_irq, rx_ready_irq, tx_ready_irq, flow_halt, xon_req, xoff_req;
	logic cts_n, dsr_n, ring_indicator_n, carrier_detect_n;
	int num_errors, check_count;
	int rxl[5] = '{16, 8, 16, 56, 60};
	int txl[5] = '{12, 8, 16, 32, 56};
	umsft_top dut_u (.clk, .nrst, .sw_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .line_control, .modem_control, .enhanced_function_control,
		.special_function_control, .special_function_unlock_code, .fifo_control,
		.msr_int_enable, .auto_rts_en, .auto_swflow_en, .rx_fifo_count, .tx_fifo_space,
		.cts_n, .dsr_n, .ring_indicator_n, .carrier_detect_n, .modem_irq, .rx_ready_irq,
		.tx_ready_irq, .flow_halt, .xon_req, .xoff_req, .xoff_char_first, .xoff_char_second);
	umsft_modem_peer peer_u (.assert_lines(lines), .cts_n, .dsr_n, .ring_indicator_n,
		.carrier_detect_n);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task cfg(input logic [7:0] lc, input logic [7:0] mc, input logic [7:0] ef,
		input logic [7:0] sf);
		line_control = lc;
		modem_control = mc;
		enhanced_function_control = ef;
		special_function_control = sf;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
		cyc(1);
	endtask
	task rchk(input string nm, input logic [3:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		chk(nm, reg_rdata, exp);
		cyc(1);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#(25 * 6000);
		num_errors++;
		conclude;
	end
	initial begin
		{nrst, sw_reset, reg_wr, reg_rd, msr_int_enable, auto_rts_en, auto_swflow_en} = 7'h00;
		{reg_addr, lines, reg_wdata, fifo_control, special_function_unlock_code} = 32'h0;
		{rx_fifo_count, tx_fifo_space} = 14'h0000;
		num_errors = 0;
		check_count = 0;
		cfg(8'h00, 8'h00, 8'h00, 8'h00);
		repeat (3) @(posedge clk);
		#1 nrst = 1'b1;
		rchk("status", 4'h6, 8'h00);
		rchk("scratch", 4'h7, 8'hFF);
		rchk("unmapped", 4'h3, 8'h00);
		cfg(8'h00, 8'h04, 8'h10, 8'h00);
		rchk("levels", 4'h6, 8'h00);
		rchk("trig", 4'h7, 8'h00);
		cfg(8'hBF, 8'h00, 8'h00, 8'h00);
		rchk("xoff_char_first", 4'h6, 8'h00);
		rchk("xoff_char_second", 4'h7, 8'h00);
		wr(4'h6, 8'h13);
		wr(4'h7, 8'h11);
		rchk("xoff_char_first_rw", 4'h6, 8'h13);
		rchk("xoff_char_second_rw", 4'h7, 8'h11);
		cfg(8'h00, 8'h00, 8'h00, 8'h00);
		wr(4'h7, 8'hA5);
		cfg(8'h00, 8'h04, 8'h10, 8'h04);
		wr(4'h6, 8'hFF);
		wr(4'h7, 8'h43);
		rchk("levels_bank", 4'h6, 8'h00);
		cfg(8'h00, 8'h04, 8'h10, 8'h00);
		rchk("levels_ignored", 4'h6, 8'h00);
		rchk("trig_rw", 4'h7, 8'h43);
		special_function_unlock_code = 8'h5A;
		cfg(8'hBF, 8'h04, 8'h10, 8'h00);
		rchk("xoff_char_second_hidden", 4'h7, 8'h43);
		special_function_unlock_code = 8'h00;
		cfg(8'h00, 8'h04, 8'h00, 8'h00);
		rchk("trig_locked", 4'h7, 8'h00);
		$display("test registers done");
		sw_reset = 1'b1;
		cyc(1);
		sw_reset = 1'b0;
		cyc(1);
		chk("xoff_char_first_port", xoff_char_first, 8'h13);
		chk("xoff_char_second_port", xoff_char_second, 8'h11);
		cfg(8'h00, 8'h00, 8'h00, 8'h00);
		rchk("scratch_kept", 4'h7, 8'hA5);
		cfg(8'h00, 8'h04, 8'h10, 8'h00);
		rchk("trig_cleared", 4'h7, 8'h00);
		$display("test soft reset done");
		// Resume at 8 and halt at 16, the halt level equal to the receive trigger of 16
		wr(4'h6, 8'h24);
		wr(4'h7, 8'h43);
		rx_fifo_count = 7'h0F;
		{auto_rts_en, auto_swflow_en} = 2'b11;
		cyc(2);
		chk("halt_below", 8'(flow_halt), 8'h00);
		rx_fifo_count = 7'h10;
		cyc(1);
		chk("halt_at", 8'({flow_halt, xoff_req}), 8'h03);
		cyc(1);
		chk("xoff_pulse", 8'(xoff_req), 8'h00);
		rx_fifo_count = 7'h09;
		cyc(2);
		chk("halt_kept", 8'(flow_halt), 8'h01);
		rx_fifo_count = 7'h08;
		cyc(1);
		chk("resume", 8'({flow_halt, xon_req}), 8'h01);
		$display("test flow done");
		for (int k = 0; k < 5; k++) begin
			if (k == 1) wr(4'h7, 8'h00);
			fifo_control = (k == 0) ? 8'h00 : {2'(k - 1), 2'(k - 1), 4'h0};
			rx_fifo_count = 7'(rxl[k] - 1);
			tx_fifo_space = 7'(txl[k] - 1);
			cyc(2);
			chk("trig_below", 8'({rx_ready_irq, tx_ready_irq}), 8'h00);
			rx_fifo_count = 7'(rxl[k]);
			tx_fifo_space = 7'(txl[k]);
			cyc(2);
			chk("trig_at", 8'({rx_ready_irq, tx_ready_irq}), 8'h03);
		end
		$display("test triggers done");
		cfg(8'h00, 8'h00, 8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			msr_int_enable = (i != 1);
			e = 8'h00;
			e[i + 4] = 1'b1;
			e[i] = (i != 2);
			lines[i] = 1'b1;
			cyc(5);
			chk("modem_irq", 8'(modem_irq), 8'((i != 1) && (i != 2)));
			rchk("status_set", 4'h6, e);
			chk("irq_clear", 8'(modem_irq), 8'h00);
			lines[i] = 1'b0;
			cyc(5);
			e = 8'h00;
			e[i] = 1'b1;
			rchk("status_back", 4'h6, e);
		end
		$display("test modem lines done");
		cfg(8'h00, 8'h1B, 8'h00, 8'h00);
		cyc(3);
		rchk("loop_enter", 4'h6, 8'hBB);
		rchk("loop_read", 4'h6, 8'hB0);
		cfg(8'h00, 8'h00, 8'h00, 8'h00);
		cyc(3);
		rchk("loop_leave", 4'h6, 8'h0B);
		$display("test loopback done");
		conclude;
	end
endmodule
